// ### gpio_pad_board.sv
/*
 Board model at the port pads: resolves the port drive, its pulls and an external
 source into pad levels. Assumes the bench clocks it with mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module gpio_pad_board (
	input  wire logic                 mclk,
	input  wire gpio_pkg::pad_drive_t pad,
	input  wire logic [7:0]           ext_val,
	input  wire logic [7:0]           ext_en,
	output logic      [7:0]           pad_in
);
	logic [7:0] last;
	// An undriven, unpulled pin shows the inverse of its last level, so nothing settles by luck.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pad_in[i] = pad.oe[i] ? pad.o[i] : ext_en[i] ? ext_val[i] :
				pad.pull_up[i] ? 1'b1 : pad.pull_down[i] ? 1'b0 : ~last[i];
		end
	end
	always_ff @(posedge mclk) begin
		last <= pad_in;
	end
endmodule
`default_nettype wire

// ### gpio_pin_drive_and_sense.sv
/*
 Pin logic of an eight-pin port: drive modes, pulls, synchronised input,
 synchronous and asynchronous sensing, two masked interrupt requests and events.
 Assumes a classic Wishbone master on mclk and a pad ring that resolves
 o/oe/pull_up/pull_down into the pin level on pad_in.
*/
// The Wishbone register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module gpio_pin_drive_and_sense #(
	parameter int PINS = gpio_pkg::PINS
) (
	input  wire logic                   mclk,
	input  wire logic                   sys_rst,
	input  wire logic                   clk_en,
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [7:0]             wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o,
	input  wire logic [PINS-1:0]        pad_in,
	output gpio_pkg::pad_drive_t        pad,
	output logic                        port_interrupt_request0,
	output logic                        port_interrupt_request1,
	output logic                        wake_request,
	output gpio_pkg::port_event_t       port_event
);
	logic [PINS-1:0]           pin_direction_bit;
	logic [PINS-1:0]           out_value;
	logic [PINS-1:0]           imask0;
	logic [PINS-1:0]           imask1;
	logic [1:0]                int_enable;
	gpio_pkg::pin_cfg_t        cfg [PINS];
	logic [PINS-1:0]           sync_stage;
	logic [PINS-1:0]           in_value;
	logic [PINS-1:0]           in_prev;
	logic [PINS-1:0]           keep_level;
	logic [PINS-1:0]           sense_hit;
	logic [PINS-1:0]           async_hit;
	logic [PINS-1:0]           raw_pin;
	logic                      edge_latch;
	logic                      edge_clr;
	logic                      wr;
	logic                      rd_cycle;
	logic [31:0]               next_rdata;

	////////////////////////////////////////////////////////////////////////////////
	// Register bus. One wait state: ack follows the request by one edge.

	assign rd_cycle = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr       = rd_cycle & wb_we_i & wb_sel_i[0] & clk_en;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
		end else if (clk_en) begin
			wb_ack_o <= rd_cycle;
		end
	end

	always_comb begin
		next_rdata = gpio_pkg::UNMAPPED_RD;
		unique case (wb_adr_i)
			gpio_pkg::OFF_DIR:    next_rdata = {24'h000000, pin_direction_bit};
			gpio_pkg::OFF_OUT:    next_rdata = {24'h000000, out_value};
			gpio_pkg::OFF_IN:     next_rdata = {24'h000000, in_value};
			gpio_pkg::OFF_IMASK0: next_rdata = {24'h000000, imask0};
			gpio_pkg::OFF_IMASK1: next_rdata = {24'h000000, imask1};
			gpio_pkg::OFF_IEN:    next_rdata = {30'h00000000, int_enable};
			default: begin
				for (int i = 0; i < PINS; i++) begin
					if (wb_adr_i == gpio_pkg::OFF_CFG0 + 8'(4 * i)) begin
						next_rdata = {24'h000000, cfg[i]};
					end
				end
			end
		endcase
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wb_dat_o <= 32'h00000000;
		end else if (clk_en && rd_cycle) begin
			wb_dat_o <= next_rdata;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_direction_bit <= gpio_pkg::REG_RESET;
			out_value         <= gpio_pkg::REG_RESET;
			imask0            <= gpio_pkg::REG_RESET;
			imask1            <= gpio_pkg::REG_RESET;
			int_enable        <= 2'h0;
			for (int i = 0; i < PINS; i++) begin
				cfg[i] <= gpio_pkg::CFG_RESET;
			end
		end else if (wr) begin
			unique case (wb_adr_i)
				gpio_pkg::OFF_DIR:    pin_direction_bit <= wb_dat_i[7:0];
				gpio_pkg::OFF_OUT:    out_value         <= wb_dat_i[7:0];
				gpio_pkg::OFF_IMASK0: imask0            <= wb_dat_i[7:0];
				gpio_pkg::OFF_IMASK1: imask1            <= wb_dat_i[7:0];
				gpio_pkg::OFF_IEN:    int_enable        <= wb_dat_i[1:0];
				default: begin
					for (int i = 0; i < PINS; i++) begin
						if (wb_adr_i == gpio_pkg::OFF_CFG0 + 8'(4 * i)) begin
							cfg[i] <= wb_dat_i[7:0];
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Input path. A disabled input holds its last synchronised value frozen.

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_stage <= '0;
			in_value   <= '0;
			in_prev    <= '0;
		end else if (clk_en) begin
			for (int i = 0; i < PINS; i++) begin
				if (!cfg[i].disable_input) begin
					sync_stage[i] <= pad_in[i];
					in_value[i]   <= sync_stage[i] ^ cfg[i].invert;
				end
			end
			in_prev <= in_value;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			keep_level <= '0;
		end else if (clk_en) begin
			keep_level <= in_value;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Drive. Pulls are weak; the pad ring lets o/oe override them.

	always_comb begin
		pad = '0;
		for (int i = 0; i < PINS; i++) begin
			unique case (cfg[i].drive)
				gpio_pkg::DRV_TOTEM, gpio_pkg::DRV_PULLDOWN, gpio_pkg::DRV_PULLUP: begin
					pad.oe[i] = pin_direction_bit[i];
					pad.o[i]  = out_value[i];
					pad.pull_down[i] = ~pin_direction_bit[i] &
						(cfg[i].drive == gpio_pkg::DRV_PULLDOWN);
					pad.pull_up[i]   = ~pin_direction_bit[i] &
						(cfg[i].drive == gpio_pkg::DRV_PULLUP);
				end
				gpio_pkg::DRV_BUSKEEP: begin
					pad.oe[i] = pin_direction_bit[i];
					pad.o[i]  = out_value[i];
					pad.pull_up[i]   = keep_level[i] ^ cfg[i].invert;
					pad.pull_down[i] = ~(keep_level[i] ^ cfg[i].invert);
				end
				gpio_pkg::DRV_WOR, gpio_pkg::DRV_WOR_PD: begin
					pad.oe[i] = pin_direction_bit[i] & out_value[i];
					pad.o[i]  = 1'b1;
					pad.pull_down[i] = (cfg[i].drive == gpio_pkg::DRV_WOR_PD);
				end
				gpio_pkg::DRV_WAND, gpio_pkg::DRV_WAND_PU: begin
					pad.oe[i] = ~out_value[i];
					pad.o[i]  = 1'b0;
					pad.pull_up[i] = (cfg[i].drive == gpio_pkg::DRV_WAND_PU);
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sensing. Clocked sense uses synchronised levels only, so events and
	// the sense_hit part of each request never see a metastable sample; the pin-two latch is not synchronised.

	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			unique case (cfg[i].sense)
				gpio_pkg::SENSE_BOTH: sense_hit[i] = in_value[i] ^ in_prev[i];
				gpio_pkg::SENSE_RISE: sense_hit[i] = in_value[i] & ~in_prev[i];
				gpio_pkg::SENSE_FALL: sense_hit[i] = ~in_value[i] & in_prev[i];
				gpio_pkg::SENSE_LOW:  sense_hit[i] = ~in_value[i];
				default:              sense_hit[i] = 1'b0;
			endcase
			port_event.signal[i] = (cfg[i].sense == gpio_pkg::SENSE_LOW) ?
				in_value[i] : sense_hit[i] & clk_en;
			port_event.data[i] = in_value[i];
		end
	end

	// Pin two keeps a clockless edge latch; it is cleared once the clocked
	// side has seen the request, so a fresh edge later sets it again.
	assign raw_pin = pad_in ^ {cfg[7].invert, cfg[6].invert, cfg[5].invert, cfg[4].invert,
		cfg[3].invert, cfg[2].invert, cfg[1].invert, cfg[0].invert};

	always_ff @(posedge raw_pin[gpio_pkg::ASYNC_PIN] or posedge edge_clr) begin
		if (edge_clr) begin
			edge_latch <= 1'b0;
		end else if (cfg[gpio_pkg::ASYNC_PIN].sense == gpio_pkg::SENSE_BOTH ||
				cfg[gpio_pkg::ASYNC_PIN].sense == gpio_pkg::SENSE_RISE) begin
			edge_latch <= 1'b1;
		end
	end

	assign edge_clr = sys_rst | (clk_en & sense_hit[gpio_pkg::ASYNC_PIN]);

	// Clockless wake for pins masked for request 1: with both-edge sense any change away from the last sampled
	// value, with low sense a low level; request 0 wakes while enabled with any mask bit set. A reverted pin wakes but sense_hit stays clear.
	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			unique case (cfg[i].sense)
				gpio_pkg::SENSE_BOTH: async_hit[i] = raw_pin[i] ^ in_value[i];
				gpio_pkg::SENSE_LOW:  async_hit[i] = ~raw_pin[i];
				default:              async_hit[i] = 1'b0;
			endcase
		end
		async_hit[gpio_pkg::ASYNC_PIN] = async_hit[gpio_pkg::ASYNC_PIN] | edge_latch;
	end

	assign wake_request = |((imask0 & {PINS{int_enable[0]}}) | (imask1 & {PINS{int_enable[1]}})
		& async_hit);

	// Request 0/1: clocked sense plus the pin-two latch, masked and enabled.
	assign port_interrupt_request0 = int_enable[0] &
		|(imask0 & (sense_hit | ({{(PINS-1){1'b0}}, edge_latch} << gpio_pkg::ASYNC_PIN)));
	assign port_interrupt_request1 = int_enable[1] &
		|(imask1 & (sense_hit | ({{(PINS-1){1'b0}}, edge_latch} << gpio_pkg::ASYNC_PIN)));

	// Reset clears direction asynchronously, which releases every pin.
endmodule
`default_nettype wire

// ### gpio_pin_drive_and_sense_asserts.sv
/*
 Checker for the port: bus answer, pad drive, synchroniser, events, interrupt gate.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_drive_and_sense_asserts #(
	parameter int PINS = gpio_pkg::PINS
) (
	input wire logic                  mclk,
	input wire logic                  sys_rst,
	input wire logic                  clk_en,
	input wire logic                  wb_cyc_i,
	input wire logic                  wb_stb_i,
	input wire logic                  wb_we_i,
	input wire logic [7:0]            wb_adr_i,
	input wire logic [3:0]            wb_sel_i,
	input wire logic [31:0]           wb_dat_i,
	input wire logic [31:0]           wb_dat_o,
	input wire logic                  wb_ack_o,
	input wire logic [PINS-1:0]       pad_in,
	input wire gpio_pkg::pad_drive_t  pad,
	input wire logic                  port_interrupt_request0,
	input wire logic                  port_interrupt_request1,
	input wire logic                  wake_request,
	input wire gpio_pkg::port_event_t port_event
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	logic [1:0] ien;
	// Mirror of the enable bits, so each request can be tied to its enable.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ien <= 2'h0;
		end else if (clk_en && wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] &&
				wb_adr_i == gpio_pkg::OFF_IEN) begin
			ien <= wb_dat_i[1:0];
		end
	end
	////////////////////////////////////////
	a_ack_answer: assert property (clk_en && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_read_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
		else $error("read data upper bits set");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'hFC |->
		wb_dat_o == 32'h00000000) else $error("unmapped read not zero");
	a_reset_release: assert property ($fell(sys_rst) |-> pad.oe == 8'h00)
		else $error("pin driven after reset");
	a_pull_drive: assert property ((pad.pull_up & pad.pull_down) == 8'h00)
		else $error("both pulls on one pin");
	a_sync_hold: assert property (($stable(pad_in) && !wb_cyc_i) [*4] |->
		$stable(port_event.data)) else $error("input moved on a steady pin");
	a_event_cause: assert property (clk_en |-> (port_event.signal & ~port_event.data &
		~(port_event.data ^ $past(port_event.data))) == 8'h00) else $error("event without cause");
	a_irq_gate: assert property ((port_interrupt_request0 -> ien[0]) &&
		(port_interrupt_request1 -> ien[1])) else $error("request while disabled");
	c_req: cover property (port_interrupt_request0 || port_interrupt_request1);
	c_event: cover property (port_event.signal != 8'h00);
	c_write: cover property (wb_ack_o && wb_we_i);
endmodule
bind gpio_pin_drive_and_sense gpio_pin_drive_and_sense_asserts #(.PINS(PINS)) checker_i (.*);
`default_nettype wire

// ### gpio_pin_drive_and_sense_test.sv
/*
 Self-checking bench for the port: drive table, keeper, input path, sensing, reset.
 Assumes the board model and the checker compile before it.
*/
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_drive_and_sense_test;
	logic                  mclk = 1'b0;
	logic                  sys_rst = 1'b1;
	logic                  cyc = 1'b0;
	logic                  stb = 1'b0;
	logic                  we = 1'b0;
	logic [7:0]            adr = 8'h00;
	logic [31:0]           wdat = 32'h00000000;
	logic [31:0]           rdat;
	logic                  ack;
	logic [7:0]            pad_in;
	logic [7:0]            ext_val = 8'hFF;
	logic [7:0]            ext_en = 8'hFF;
	logic                  req0;
	logic                  req1;
	logic                  wake;
	gpio_pkg::pad_drive_t  pad;
	gpio_pkg::port_event_t ev;
	logic [3:0]            pad0;
	logic [31:0]           q;
	int                    h;
	int                    num_errors = 0;
	int                    checks = 0;
	// Row: drive mode, direction, out, then expected oe, driven level, pull-up, pull-down.
	logic [8:0]            rows [16] = '{9'h03C, 9'h028, 9'h010, 9'h081, 9'h0BC, 9'h0C2,
		9'h0E8, 9'h13C, 9'h120, 9'h110, 9'h148, 9'h170, 9'h1BD, 9'h181, 9'h1EA, 9'h1D2};
	// Row: configuration byte, then whether a fall and a rise should hit.
	logic [9:0]            senses [3] = '{10'h005, 10'h00A, 10'h003};
	assign pad0 = {pad.oe[0], pad.o[0] & pad.oe[0], pad.pull_up[0], pad.pull_down[0]};
	always #2.5 mclk = ~mclk;
	gpio_pin_drive_and_sense DUT (
		.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .pad_in(pad_in), .pad(pad), .port_interrupt_request0(req0),
		.port_interrupt_request1(req1), .wake_request(wake), .port_event(ev));
	gpio_pad_board board (.mclk(mclk), .pad(pad), .ext_val(ext_val), .ext_en(ext_en),
		.pad_in(pad_in));
	////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		chk("ack", ack, 32'h1);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic watch(input logic [7:0] v, input int skip, input int pin);
		ext_val <= v;
		h = 0;
		repeat (skip) @(posedge mclk);
		repeat (8) begin
			@(posedge mclk);
			h += ((req0 | req1) === 1'b1) + 16 * (ev.signal[pin] === 1'b1);
		end
	endtask
	task automatic conclude();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge mclk);
		num_errors++;
		conclude();
	end
	initial begin
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		bus(1'b0, 8'hFC, 8'h00);
		chk("unmapped", q, 32'h0);
		ext_en <= 8'hFE;
		foreach (rows[i]) begin
			bus(1'b1, gpio_pkg::OFF_CFG0, {2'h0, rows[i][8:6], 3'h7});
			bus(1'b1, gpio_pkg::OFF_DIR, {7'h00, rows[i][5]});
			bus(1'b1, gpio_pkg::OFF_OUT, {7'h00, rows[i][4]});
			chk("pad0", pad0, rows[i][3:0]);
		end
		bus(1'b1, gpio_pkg::OFF_CFG0, 8'h0F);
		for (int v = 0; v < 2; v++) begin
			ext_val[0] <= v[0];
			ext_en[0] <= 1'b1;
			repeat (4) @(posedge mclk);
			ext_en[0] <= 1'b0;
			repeat (4) @(posedge mclk);
			chk("keeper", {pad.pull_up[0], pad.pull_down[0]}, {v[0], ~v[0]});
		end
		ext_en <= 8'hFF;
		ext_val <= 8'hA5;
		repeat (4) @(posedge mclk);
		ext_val <= 8'h5A;
		@(posedge mclk);
		#1 chk("sync1", ev.data, 32'hA5);
		@(posedge mclk);
		#1 chk("sync2", ev.data, 32'h5A);
		@(posedge mclk);
		bus(1'b1, gpio_pkg::OFF_CFG0 + 8'h04, 8'h87);
		ext_val <= 8'h58;
		repeat (4) @(posedge mclk);
		bus(1'b0, gpio_pkg::OFF_IN, 8'h00);
		chk("in", q, 32'h5A);
		bus(1'b1, gpio_pkg::OFF_IMASK0, 8'h08);
		bus(1'b1, gpio_pkg::OFF_CFG0 + 8'h0C, 8'h01);
		watch(8'h50, 0, 3);
		watch(8'h58, 0, 3);
		chk("irq_off", h, 16);
		bus(1'b1, gpio_pkg::OFF_IEN, 8'h03);
		foreach (senses[i]) begin
			bus(1'b1, gpio_pkg::OFF_CFG0 + 8'h0C, senses[i][9:2]);
			watch(8'h50, 0, 3);
			chk("fall", h, senses[i][1] ? 17 : 0);
			watch(8'h58, 0, 3);
			chk("rise", h, senses[i][0] ? 17 : 0);
		end
		bus(1'b1, gpio_pkg::OFF_IMASK1, 8'h10);
		bus(1'b1, gpio_pkg::OFF_CFG0 + 8'h10, 8'h03);
		watch(8'h48, 4, 4);
		chk("low", h, 8);
		watch(8'h58, 4, 4);
		chk("high", h, 128);
		bus(1'b1, gpio_pkg::OFF_CFG0 + 8'h08, 8'h01);
		bus(1'b1, gpio_pkg::OFF_IMASK0, 8'h04);
		ext_val <= 8'h5C;
		#1 chk("async_req", {wake, req0}, 32'h3);
		repeat (4) @(posedge mclk);
		chk("async_clear", req0, 32'h0);
		bus(1'b1, gpio_pkg::OFF_DIR, 8'hFF);
		sys_rst <= 1'b1;
		#1 chk("reset_oe", pad.oe, 32'h0);
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		bus(1'b0, gpio_pkg::OFF_IEN, 8'h00);
		chk("ien_reset", q, 32'h0);
		conclude();
	end
endmodule
`default_nettype wire

// ### gpio_pkg.sv
/*
 Package for the eight-pin general purpose port: register offsets, field layouts,
 reset values, drive and sense encodings, and the carrier structs.
 Assumes a 32-bit classic Wishbone register bus with word-aligned registers.
*/
`default_nettype none
package gpio_pkg;
	localparam int          PINS        = 8;
	localparam logic [7:0]  OFF_DIR     = 8'h00;
	localparam logic [7:0]  OFF_OUT     = 8'h04;
	localparam logic [7:0]  OFF_IN      = 8'h08;
	localparam logic [7:0]  OFF_IMASK0  = 8'h0C;
	localparam logic [7:0]  OFF_IMASK1  = 8'h10;
	localparam logic [7:0]  OFF_IEN     = 8'h14;
	localparam logic [7:0]  OFF_CFG0    = 8'h20;
	localparam int          ASYNC_PIN   = 2;
	localparam int          CFG_SENSE_LSB = 0;
	localparam int          CFG_DRIVE_LSB = 3;
	localparam int          CFG_INV_BIT   = 6;
	localparam int          CFG_DIS_BIT   = 7;
	localparam logic [7:0]  CFG_RESET   = 8'h00;
	localparam logic [7:0]  REG_RESET   = 8'h00;
	localparam logic [31:0] UNMAPPED_RD = 32'h00000000;

	typedef enum logic [2:0] {
		SENSE_BOTH    = 3'h0,
		SENSE_RISE    = 3'h1,
		SENSE_FALL    = 3'h2,
		SENSE_LOW     = 3'h3,
		SENSE_DISABLE = 3'h7
	} sense_t;

	typedef enum logic [2:0] {
		DRV_TOTEM     = 3'h0,
		DRV_BUSKEEP   = 3'h1,
		DRV_PULLDOWN  = 3'h2,
		DRV_PULLUP    = 3'h3,
		DRV_WOR       = 3'h4,
		DRV_WAND      = 3'h5,
		DRV_WOR_PD    = 3'h6,
		DRV_WAND_PU   = 3'h7
	} drive_t;

	typedef struct packed {
		logic       disable_input;
		logic       invert;
		drive_t     drive;
		sense_t     sense;
	} pin_cfg_t;

	typedef struct packed {
		logic [7:0] o;
		logic [7:0] oe;
		logic [7:0] pull_up;
		logic [7:0] pull_down;
	} pad_drive_t;

	typedef struct packed {
		logic [7:0] signal;
		logic [7:0] data;
	} port_event_t;
endpackage
`default_nettype wire
